//--- verilog/slpc_ctrl.sv
// Sleep mode controller: sleep entry, clock gating, wake sources and monitor control.
`timescale 1ns/1ns
`include "slpc_cfg.svh"
module slpc_ctrl #(
  parameter logic [15:0] BOD_WAKE_CYCLES = 16'(`SLPC_BOD_WAKE_CYC)
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        sleep_arm,
  input  wire logic [1:0]  sleep_select,
  input  wire logic        sleep_instr,
  input  wire logic        ctrl_wr,
  input  wire logic        wr_sleep_off,
  input  wire logic        wr_sleep_off_en,
  input  wire logic        adc_enabled,
  input  wire logic        timer_async_sel,
  input  wire logic [15:0] wake_startup_cycles,
  input  wire logic        reset_event,
  input  wire logic [1:0]  ext_irq_level,
  input  wire logic [1:0]  ext_irq_edge,
  input  wire logic        pin_change_irq,
  input  wire logic        usi_start_irq,
  input  wire logic        wdt_irq,
  input  wire logic        adc_done_irq,
  input  wire logic        spm_ready_irq,
  input  wire logic        timer0_irq,
  input  wire logic        other_io_irq,
  output logic             core_clk,
  output logic             flash_clk,
  output logic             io_clk,
  output logic             converter_clk,
  output logic             async_timer_clk,
  output logic             main_osc_en,
  output logic             brownout_monitor,
  output logic             brownout_sleep_off,
  output logic             adc_start,
  output logic             core_halt,
  output logic             core_continue,
  output logic             core_irq_resume,
  output logic             core_restart,
  output logic             sleeping,
  output logic             state_retain
);

  slpc_pkg::slpc_state_t s_reg;
  slpc_pkg::slpc_state_t s_next;
  logic                  timer_start;
  logic [15:0]           timer_load;
  logic                  timer_done;
  logic                  wake_hit;
  logic                  ext_level_any;
  logic                  async_timer_hit;
  logic                  deep_hit;
  logic [15:0]           wake_delay;

  // ****************************************
  // Wake source selection
  // ****************************************
  assign ext_level_any   = |ext_irq_level;
  assign async_timer_hit = timer0_irq && timer_async_sel;
  assign deep_hit        = wdt_irq || usi_start_irq || ext_level_any || pin_change_irq;

  always_comb begin
    wake_hit = 1'b0;
    unique case (s_reg.mode)
      `SLPC_SEL_IDLE: begin
        wake_hit = ext_level_any || (|ext_irq_edge) || pin_change_irq || usi_start_irq ||
                   wdt_irq || adc_done_irq || spm_ready_irq || timer0_irq ||
                   other_io_irq;
      end
      `SLPC_SEL_ADCNR: begin
        wake_hit = adc_done_irq || deep_hit || async_timer_hit || spm_ready_irq;
      end
      `SLPC_SEL_PDOWN: begin
        wake_hit = deep_hit;
      end
      `SLPC_SEL_PSAVE: begin
        wake_hit = deep_hit || async_timer_hit;
      end
    endcase
  end

  // Deep modes wait for the oscillator; a monitor-off sleep waits for the monitor.
  always_comb begin
    wake_delay = s_reg.mode[1] ? wake_startup_cycles : 16'h0000;
    if (s_reg.bod_off_now && (wake_delay < BOD_WAKE_CYCLES)) begin
      wake_delay = BOD_WAKE_CYCLES;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    s_next                 = s_reg;
    s_next.adc_start       = 1'b0;
    s_next.core_continue   = 1'b0;
    s_next.core_irq_resume = 1'b0;
    s_next.core_restart    = 1'b0;
    timer_start            = 1'b0;
    timer_load             = 16'h0000;

    // Timed write window for the monitor sleep-off bit.
    if (s_reg.seq_cnt != 3'h0) begin
      s_next.seq_cnt = s_reg.seq_cnt - 3'h1;
    end
    if (ctrl_wr) begin
      if (wr_sleep_off && wr_sleep_off_en) begin
        if (s_reg.seq_cnt == 3'h0) begin
          s_next.seq_cnt = `SLPC_SEQ_CYCLES;
        end
      end else if (!wr_sleep_off_en && (s_reg.seq_cnt != 3'h0)) begin
        s_next.sleep_off = wr_sleep_off;
        s_next.seq_cnt   = 3'h0;
      end
    end

    unique case (s_reg.st)
      slpc_pkg::slpc_st_active: begin
        if (sleep_instr && sleep_arm) begin
          s_next.st           = slpc_pkg::slpc_st_sleep;
          s_next.mode         = sleep_select;
          s_next.core_halt    = 1'b1;
          s_next.core_clk_en  = 1'b0;
          s_next.flash_clk_en = 1'b0;
          unique case (sleep_select)
            `SLPC_SEL_IDLE: begin
              s_next.io_clk_en          = 1'b1;
              s_next.converter_clk_en   = 1'b1;
              s_next.async_timer_clk_en = 1'b1;
              s_next.main_osc_en        = 1'b1;
            end
            `SLPC_SEL_ADCNR: begin
              s_next.io_clk_en          = 1'b0;
              s_next.converter_clk_en   = 1'b1;
              s_next.async_timer_clk_en = 1'b1;
              s_next.main_osc_en        = 1'b1;
            end
            `SLPC_SEL_PDOWN: begin
              s_next.io_clk_en          = 1'b0;
              s_next.converter_clk_en   = 1'b0;
              s_next.async_timer_clk_en = 1'b0;
              s_next.main_osc_en        = 1'b0;
            end
            `SLPC_SEL_PSAVE: begin
              s_next.io_clk_en          = 1'b0;
              s_next.converter_clk_en   = 1'b0;
              s_next.async_timer_clk_en = 1'b1;
              s_next.main_osc_en        = 1'b0;
            end
          endcase
          // Only the deep modes may drop the monitor.
          s_next.bod_off_now         = s_reg.sleep_off && sleep_select[1];
          s_next.brownout_monitor_en = !(s_reg.sleep_off && sleep_select[1]);
          s_next.adc_start           = adc_enabled && !sleep_select[1];
          s_next.restart             = 1'b0;
        end else if (sleep_instr) begin
          s_next.core_continue = 1'b1;
        end
      end
      slpc_pkg::slpc_st_sleep: begin
        if (reset_event || wake_hit) begin
          s_next.st                  = slpc_pkg::slpc_st_wake;
          s_next.restart             = reset_event;
          s_next.main_osc_en         = 1'b1;
          s_next.brownout_monitor_en = 1'b1;
          s_next.sleep_off           = 1'b0;
          timer_start                = 1'b1;
          timer_load                 = wake_delay;
        end
      end
      slpc_pkg::slpc_st_wake: begin
        if (reset_event) begin
          s_next.restart = 1'b1;
        end
        if (timer_done) begin
          s_next.st                 = slpc_pkg::slpc_st_halt;
          s_next.io_clk_en          = 1'b1;
          s_next.converter_clk_en   = 1'b1;
          s_next.async_timer_clk_en = 1'b1;
          s_next.bod_off_now        = 1'b0;
          timer_start               = 1'b1;
          timer_load                = `SLPC_HALT_CYCLES;
        end
      end
      slpc_pkg::slpc_st_halt: begin
        if (reset_event) begin
          s_next.restart = 1'b1;
        end
        if (timer_done) begin
          s_next.st              = slpc_pkg::slpc_st_active;
          s_next.core_halt       = 1'b0;
          s_next.core_clk_en     = 1'b1;
          s_next.flash_clk_en    = 1'b1;
          s_next.core_restart    = s_reg.restart || reset_event;
          s_next.core_irq_resume = !(s_reg.restart || reset_event);
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg                     <= '0;
      s_reg.st                  <= slpc_pkg::slpc_st_active;
      s_reg.core_clk_en         <= 1'b1;
      s_reg.flash_clk_en        <= 1'b1;
      s_reg.io_clk_en           <= 1'b1;
      s_reg.converter_clk_en    <= 1'b1;
      s_reg.async_timer_clk_en  <= 1'b1;
      s_reg.main_osc_en         <= 1'b1;
      s_reg.brownout_monitor_en <= 1'b1;
      s_reg.state_retain        <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  slpc_wake_timer u_timer (
    .clk   (clk),
    .rstn  (rstn),
    .start (timer_start),
    .load  (timer_load),
    .done  (timer_done)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign core_clk           = s_reg.core_clk_en;
  assign flash_clk          = s_reg.flash_clk_en;
  assign io_clk             = s_reg.io_clk_en;
  assign converter_clk      = s_reg.converter_clk_en;
  assign async_timer_clk    = s_reg.async_timer_clk_en;
  assign main_osc_en        = s_reg.main_osc_en;
  assign brownout_monitor   = s_reg.brownout_monitor_en;
  assign brownout_sleep_off = s_reg.sleep_off;
  assign adc_start          = s_reg.adc_start;
  assign core_halt          = s_reg.core_halt;
  assign core_continue      = s_reg.core_continue;
  assign core_irq_resume    = s_reg.core_irq_resume;
  assign core_restart       = s_reg.core_restart;
  assign sleeping           = s_reg.st == slpc_pkg::slpc_st_sleep;
  assign state_retain       = s_reg.state_retain;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic in_sleep;
  logic in_halt;
  assign in_sleep = s_reg.st == slpc_pkg::slpc_st_sleep;
  assign in_halt  = s_reg.st == slpc_pkg::slpc_st_halt;

  idle_clocks_a: assert property (in_sleep && s_reg.mode == `SLPC_SEL_IDLE |->
    !core_clk && !flash_clk && io_clk && converter_clk && async_timer_clk)
    else $error("idle clock gating wrong");
  adcnr_clocks_a: assert property (in_sleep && s_reg.mode == `SLPC_SEL_ADCNR |->
    !core_clk && !io_clk && converter_clk && async_timer_clk)
    else $error("noise reduction clock gating wrong");
  pdown_clocks_a: assert property (in_sleep && s_reg.mode == `SLPC_SEL_PDOWN |->
    !main_osc_en && !io_clk && !converter_clk && !async_timer_clk)
    else $error("power-down clock gating wrong");
  psave_clocks_a: assert property (in_sleep && s_reg.mode == `SLPC_SEL_PSAVE |->
    !main_osc_en && !io_clk && async_timer_clk)
    else $error("power-save clock gating wrong");
  halt_four_a: assert property ($rose(in_halt) |-> in_halt[*4] ##1 !in_halt)
    else $error("wake halt not four cycles");
  bod_shallow_on_a: assert property (in_sleep && !s_reg.mode[1] |-> brownout_monitor)
    else $error("monitor off in shallow mode");
  bod_wake_on_a: assert property ($fell(in_sleep) |-> brownout_monitor && !brownout_sleep_off)
    else $error("monitor not restored on wake");
  noarm_continue_a: assert property (s_reg.st == slpc_pkg::slpc_st_active && sleep_instr &&
    !sleep_arm |=> core_continue && !in_sleep)
    else $error("unarmed sleep not ignored");
  reset_wake_a: assert property (in_sleep && reset_event |=> !in_sleep && s_reg.restart)
    else $error("reset did not start a restart wake");
  reset_done_a: assert property (in_halt && timer_done && s_reg.restart |=> core_restart)
    else $error("reset did not restart core");
  adc_start_a: assert property (s_reg.st == slpc_pkg::slpc_st_active && sleep_instr &&
    sleep_arm && adc_enabled && !sleep_select[1] |=> adc_start)
    else $error("adc conversion not started");
  edge_no_wake_a: assert property (in_sleep && s_reg.mode[1] && !reset_event && !deep_hit &&
    !async_timer_hit |=> in_sleep)
    else $error("deep sleep woke on wrong source");
  seq_guard_a: assert property (ctrl_wr && !wr_sleep_off_en && s_reg.seq_cnt == 3'h0 &&
    !in_sleep && s_reg.st != slpc_pkg::slpc_st_wake |=> $stable(brownout_sleep_off))
    else $error("sleep-off written outside window");

  idle_entry_c: cover property (s_reg.st == slpc_pkg::slpc_st_active ##1 in_sleep &&
    s_reg.mode == `SLPC_SEL_IDLE);
  pdown_wake_c: cover property (in_sleep && s_reg.mode == `SLPC_SEL_PDOWN ##1 !in_sleep);
  reset_wake_c: cover property (core_restart);
  bod_off_c: cover property (in_sleep && !brownout_monitor);

endmodule

//--- verilog/slpc_cfg.svh
// Constants of the sleep mode controller.
`ifndef SLPC_CFG_SVH
`define SLPC_CFG_SVH

`define SLPC_SEL_IDLE     2'h0
`define SLPC_SEL_ADCNR    2'h1
`define SLPC_SEL_PDOWN    2'h2
`define SLPC_SEL_PSAVE    2'h3
`define SLPC_SEQ_CYCLES   3'h4
`define SLPC_HALT_CYCLES  16'h0004
`define SLPC_CLK_MHZ      100
`define SLPC_BOD_WAKE_US  60
`define SLPC_BOD_WAKE_CYC (`SLPC_BOD_WAKE_US * `SLPC_CLK_MHZ)

`endif

//--- verilog/slpc_pkg.sv
// Types of the sleep mode controller.
package slpc_pkg;

  typedef enum logic [3:0] {
    slpc_st_active = 4'h1,
    slpc_st_sleep  = 4'h2,
    slpc_st_wake   = 4'h4,
    slpc_st_halt   = 4'h8
  } slpc_fsm_t;

  typedef struct packed {
    slpc_fsm_t   st;
    logic [1:0]  mode;
    logic        bod_off_now;
    logic        restart;
    logic        sleep_off;
    logic [2:0]  seq_cnt;
    logic        core_clk_en;
    logic        flash_clk_en;
    logic        io_clk_en;
    logic        converter_clk_en;
    logic        async_timer_clk_en;
    logic        main_osc_en;
    logic        brownout_monitor_en;
    logic        adc_start;
    logic        core_halt;
    logic        core_continue;
    logic        core_irq_resume;
    logic        core_restart;
    logic        state_retain;
  } slpc_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        run;
  } slpc_timer_t;

endpackage

//--- verilog/slpc_wake_timer.sv
// Down counter that times wake-up start-up and core halt periods.
`timescale 1ns/1ns
module slpc_wake_timer (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        start,
  input  wire logic [15:0] load,
  output logic             done
);

  slpc_pkg::slpc_timer_t t_reg;
  slpc_pkg::slpc_timer_t t_next;

  // A load of zero or one ends after one cycle; a load of n ends after n cycles.
  assign done = t_reg.run && (t_reg.cnt <= 16'h0001);

  always_comb begin
    t_next = t_reg;
    if (start) begin
      t_next.cnt = load;
      t_next.run = 1'b1;
    end else if (done) begin
      t_next.run = 1'b0;
      t_next.cnt = 16'h0000;
    end else if (t_reg.run) begin
      t_next.cnt = t_reg.cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

endmodule

//--- testbench/slpc_core_model.sv
// Model of the CPU core and of an external level wake source.
`timescale 1ns/1ns
module slpc_core_model (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic sleeping,
  input  wire logic level_req,
  output logic      sleep_instr,
  output logic      ctrl_wr,
  output logic      wr_sleep_off,
  output logic      wr_sleep_off_en,
  output logic      ext_level
);
  // ********************
  // Core instructions
  // ********************
  initial begin
    sleep_instr = 1'b0;
    ctrl_wr = 1'b0;
    wr_sleep_off = 1'b0;
    wr_sleep_off_en = 1'b0;
  end

  // Issues the sleep instruction for one cycle; arm and select are set beforehand.
  task automatic do_sleep();
    @(posedge clk);
    #1 sleep_instr = 1'b1;
    @(posedge clk);
    #1 sleep_instr = 1'b0;
  endtask

  // Writes the sleep-off bit, optionally preceded by the change-enable write.
  task automatic write_off(input logic en_first, input logic val);
    @(posedge clk);
    #1 ctrl_wr = 1'b1;
    wr_sleep_off = 1'b1;
    wr_sleep_off_en = en_first;
    @(posedge clk);
    #1 wr_sleep_off = val;
    wr_sleep_off_en = 1'b0;
    @(posedge clk);
    #1 ctrl_wr = 1'b0;
  endtask

  // ********************
  // Level wake source
  // ********************
  // The level is held until the controller has left the sleep state.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_level <= 1'b0;
    end else if (level_req && sleeping) begin
      ext_level <= #1 1'b1;
    end else if (!sleeping) begin
      ext_level <= #1 1'b0;
    end
  end
endmodule

//--- testbench/slpc_ctrl_tb.sv
// Self-checking testbench of the sleep mode controller.
`timescale 1ns/1ns
module slpc_ctrl_tb;
  localparam int BOD_CYC = 20;
  localparam int START   = 8;
  logic       clk;
  logic       rstn;
  logic       sleep_arm;
  logic [1:0] sleep_select;
  logic       adc_enabled;
  logic       timer_async_sel;
  logic [7:0] src;
  logic       sleep_instr, ctrl_wr, wr_sleep_off, wr_sleep_off_en, ext_level;
  logic       core_clk, flash_clk, io_clk, converter_clk, async_timer_clk;
  logic       main_osc_en, brownout_monitor, brownout_sleep_off, adc_start, core_halt;
  logic       core_continue, core_irq_resume, core_restart, sleeping, state_retain;
  int         fails;
  int         cmp_count;

  slpc_ctrl #(.BOD_WAKE_CYCLES(16'h0014)) i_slpc_ctrl (
    .clk(clk), .rstn(rstn), .sleep_arm(sleep_arm), .sleep_select(sleep_select),
    .sleep_instr(sleep_instr), .ctrl_wr(ctrl_wr), .wr_sleep_off(wr_sleep_off),
    .wr_sleep_off_en(wr_sleep_off_en), .adc_enabled(adc_enabled),
    .timer_async_sel(timer_async_sel), .wake_startup_cycles(16'h0008),
    .reset_event(src[6]), .ext_irq_level({1'b0, ext_level}), .ext_irq_edge({1'b0, src[1]}),
    .pin_change_irq(src[7]), .usi_start_irq(1'b0), .wdt_irq(src[0]),
    .adc_done_irq(src[4]), .spm_ready_irq(1'b0), .timer0_irq(src[5]),
    .other_io_irq(src[2]), .core_clk(core_clk), .flash_clk(flash_clk), .io_clk(io_clk),
    .converter_clk(converter_clk), .async_timer_clk(async_timer_clk),
    .main_osc_en(main_osc_en), .brownout_monitor(brownout_monitor),
    .brownout_sleep_off(brownout_sleep_off), .adc_start(adc_start), .core_halt(core_halt),
    .core_continue(core_continue), .core_irq_resume(core_irq_resume),
    .core_restart(core_restart), .sleeping(sleeping), .state_retain(state_retain)
  );

  slpc_core_model i_slpc_core_model (
    .clk(clk), .rstn(rstn), .sleeping(sleeping), .level_req(src[3]),
    .sleep_instr(sleep_instr), .ctrl_wr(ctrl_wr), .wr_sleep_off(wr_sleep_off),
    .wr_sleep_off_en(wr_sleep_off_en), .ext_level(ext_level)
  );

  // ********************
  // Tasks
  // ********************
  task automatic chk_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_cnt(input string name, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic final_report();
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic enter(input logic [1:0] sel);
    sleep_select = sel;
    i_slpc_core_model.do_sleep();
    chk_bit("sleeping", 1'b1, sleeping);
    chk_bit("core_halt", 1'b1, core_halt);
  endtask

  // Raises wake sources and counts edges up to the resume or restart pulse; exp_n 0 means no wake.
  task automatic wake(input logic [7:0] s, input int exp_n, input logic exp_rst);
    int n;
    n = 0;
    src = s;
    while (n < (exp_n == 0 ? 20 : 40) && core_irq_resume !== 1'b1 && core_restart !== 1'b1) begin
      @(posedge clk);
      #1 n++;
      if (n == 1 && exp_n != 0) begin
        src = 8'h00;
      end
    end
    src = 8'h00;
    if (exp_n == 0) begin
      chk_bit("sleeping", 1'b1, sleeping);
    end else begin
      chk_cnt("wake_cycles", exp_n, n);
      chk_bit("core_restart", exp_rst, core_restart);
      chk_bit("core_clk", 1'b1, core_clk);
      chk_bit("core_halt", 1'b0, core_halt);
      chk_bit("brownout_monitor", 1'b1, brownout_monitor);
      repeat (2) @(posedge clk);
      #1;
    end
  endtask

  // ********************
  // Clock, watchdog and tests
  // ********************
  always #5 clk = ~clk;

  // The tests take under a thousand cycles; ten thousand means a hang.
  initial begin
    #100000;
    fails++;
    final_report();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    sleep_arm = 1'b0;
    sleep_select = 2'h0;
    adc_enabled = 1'b1;
    timer_async_sel = 1'b0;
    src = 8'h00;
    fails = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    chk_bit("io_clk", 1'b1, io_clk);
    chk_bit("brownout_sleep_off", 1'b0, brownout_sleep_off);
    chk_bit("state_retain", 1'b1, state_retain);
    sleep_select = 2'h2;
    i_slpc_core_model.do_sleep();
    chk_bit("core_continue", 1'b1, core_continue);
    chk_bit("sleeping", 1'b0, sleeping);
    sleep_arm = 1'b1;
    for (logic [2:0] m = 3'h0; m < 3'h4; m++) begin
      enter(m[1:0]);
      chk_bit("core_clk", 1'b0, core_clk);
      chk_bit("flash_clk", 1'b0, flash_clk);
      chk_bit("io_clk", m == 3'h0, io_clk);
      chk_bit("converter_clk", m < 3'h2, converter_clk);
      chk_bit("async_timer_clk", m != 3'h2, async_timer_clk);
      chk_bit("main_osc_en", m < 3'h2, main_osc_en);
      chk_bit("adc_start", m < 3'h2, adc_start);
      chk_bit("brownout_monitor", 1'b1, brownout_monitor);
      wake(m == 3'h3 ? 8'h80 : 8'h01, m < 3'h2 ? 6 : START + 5, 1'b0);
      chk_bit("state_retain", 1'b1, state_retain);
    end
    adc_enabled = 1'b0;
    enter(2'h0);
    chk_bit("adc_start", 1'b0, adc_start);
    wake(8'h02, 6, 1'b0);
    enter(2'h2);
    wake(8'h02, 0, 1'b0);
    wake(8'h04, 0, 1'b0);
    wake(8'h08, START + 6, 1'b0);
    enter(2'h1);
    wake(8'h04, 0, 1'b0);
    wake(8'h10, 6, 1'b0);
    timer_async_sel = 1'b1;
    enter(2'h3);
    wake(8'h20, START + 5, 1'b0);
    i_slpc_core_model.write_off(1'b0, 1'b1);
    chk_bit("brownout_sleep_off", 1'b0, brownout_sleep_off);
    i_slpc_core_model.write_off(1'b1, 1'b1);
    chk_bit("brownout_sleep_off", 1'b1, brownout_sleep_off);
    enter(2'h0);
    chk_bit("brownout_monitor", 1'b1, brownout_monitor);
    wake(8'h01, 6, 1'b0);
    chk_bit("brownout_sleep_off", 1'b0, brownout_sleep_off);
    i_slpc_core_model.write_off(1'b1, 1'b1);
    enter(2'h2);
    chk_bit("brownout_monitor", 1'b0, brownout_monitor);
    wake(8'h01, BOD_CYC + 5, 1'b0);
    chk_bit("brownout_sleep_off", 1'b0, brownout_sleep_off);
    enter(2'h3);
    wake(8'h40, START + 5, 1'b1);
    final_report();
  end
endmodule
